// *** design/btd_decoder.sv ***
// Decode and execute slice for bit tests, subroutine call and clears.
// Assumes the core presents one instruction per cycle with its address, and
// returns the addressed file register contents combinationally.
`timescale 1ns/100ps
// Functional notes
// - Skip-if-clear: bit one runs next instruction, bit zero replaces it with NOP.
// - Skip-if-set decodes 01 011b bbff ffff, bit 0..7, file 00h..3Fh, no flags.
// - Skip-if-set: bit zero runs next instruction, bit one replaces it with NOP.
// - Call first pushes the address after the call onto the return stack.
// - Call loads the 12-bit target into the program counter, flags untouched.
// - Call takes exactly two instruction cycles.
// - Clear-file decodes 00 0001 1fff ffff, writes 00h, sets zero flag, one cycle.
// - Clear-working decodes 00 0001 0100 0000, writes 00h to W, sets zero flag.
module btd_decoder
    import btd_pkg::*;
(
    // Clock and reset
    input  wire logic               clk_in,
    input  wire logic               rst_in,
    // Instruction fetch
    input  wire logic [INSTR_W-1:0] instr_in,
    input  wire logic               instr_valid_in,
    input  wire logic [PC_W-1:0]    pc_in,
    // File register read
    output logic [FADDR_W-1:0]      file_addr_out,
    input  wire logic [DATA_W-1:0]  file_data_in,
    // File register write
    output logic                    file_we_out,
    output logic [DATA_W-1:0]       file_wdata_out,
    // Working register and zero flag
    output logic                    work_we_out,
    output logic [DATA_W-1:0]       work_wdata_out,
    output logic                    zero_set_out,
    // Program counter and stack
    output logic                    pc_load_out,
    output logic [PC_W-1:0]         pc_target_out,
    output logic                    stack_push_out,
    output logic [PC_W-1:0]         stack_top_entry_out,
    // Sequencing
    output logic                    stall_out,
    output logic                    discard_out
);
    // Sequencer state.
    btd_state_t         state;
    btd_state_t         next_state;
    logic               in_exec;
    logic               in_flush;
    logic               in_call2;

    // Class strobes from the pattern matcher.
    logic               is_tc;
    logic               is_ts;
    logic               is_call;
    logic               is_zf;
    logic               is_zw;
    logic               is_test;

    // Operand fields.
    logic [2:0]         bit_sel;
    logic [DATA_W-1:0]  bit_onehot;
    logic               bit_val;
    logic [FADDR_W-1:0] test_addr;
    logic [FADDR_W-1:0] plain_addr;
    logic [PC_W-1:0]    return_addr;

    // Execute qualifiers.
    logic               exec;
    logic               skip_on_clear;
    logic               skip_on_set;
    logic               skip;
    logic               do_call;
    logic               do_zf;
    logic               do_zw;
    logic               go_flush;
    logic               go_call2;

    // Next values of the registered outputs.
    logic [DATA_W-1:0]  next_file_wdata;
    logic [DATA_W-1:0]  next_work_wdata;
    logic [PC_W-1:0]    next_stack_top_entry;

    btd_opcode_match u_match (
        .instr_in          (instr_in),
        .is_test_clear_out (is_tc),
        .is_test_set_out   (is_ts),
        .is_call_out       (is_call),
        .is_zero_file_out  (is_zf),
        .is_zero_work_out  (is_zw)
    );

    assign in_exec  = (state == BTD_EXEC);
    assign in_flush = (state == BTD_FLUSH);
    assign in_call2 = (state == BTD_CALL2);
    assign exec     = instr_valid_in && in_exec;
    assign is_test  = is_tc || is_ts;

    // A one-hot mask keeps the tested bit an AND-OR tree instead of a variable index.
    assign bit_sel = instr_in[BIT_HI:BIT_LO];
    for (genvar b = 0; b < DATA_W; b++) begin : g_bit
        assign bit_onehot[b] = (bit_sel == 3'(b));
    end
    assign bit_val = |(bit_onehot & file_data_in);

    // The test itself never touches a flag; it only decides the fate of the next slot.
    assign skip_on_clear = is_tc && !bit_val;
    assign skip_on_set   = is_ts && bit_val;
    assign skip          = exec && (skip_on_clear || skip_on_set);
    assign do_call       = exec && is_call;
    assign do_zf         = exec && is_zf;
    assign do_zw         = exec && is_zw;
    assign go_flush      = skip;
    assign go_call2      = do_call;

    // Bit tests only reach files 00h..3Fh, so the top address bit is forced low.
    assign test_addr     = {1'b0, instr_in[TFILE_HI:0]};
    assign plain_addr    = instr_in[FADDR_W-1:0];
    assign file_addr_out = is_test ? test_addr : plain_addr;

    // Write strobes are suppressed while a discarded slot is flushed.
    assign file_we_out    = do_zf;
    assign work_we_out    = do_zw;
    assign zero_set_out   = do_zf || do_zw;
    assign stack_push_out = do_call;
    assign pc_load_out    = do_call;
    assign pc_target_out  = instr_in[PC_W-1:0];
    assign stall_out      = in_call2;
    assign discard_out    = in_flush;

    assign return_addr          = pc_in + PC_ONE;
    assign next_file_wdata      = ZERO_DATA;
    assign next_work_wdata      = ZERO_DATA;
    // The entry is held between calls, so the stack may take it on the cycle after the push strobe.
    assign next_stack_top_entry = do_call ? return_addr : stack_top_entry_out;

    always_comb begin
        next_state = BTD_EXEC;
        unique case (state)
            BTD_EXEC: begin
                if (go_flush) begin
                    next_state = BTD_FLUSH;
                end else if (go_call2) begin
                    next_state = BTD_CALL2;
                end
            end
            BTD_FLUSH: begin
                next_state = BTD_EXEC;
            end
            BTD_CALL2: begin
                next_state = BTD_EXEC;
            end
        endcase
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state <= BTD_EXEC;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            file_wdata_out <= ZERO_DATA;
        end else begin
            file_wdata_out <= next_file_wdata;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            work_wdata_out <= ZERO_DATA;
        end else begin
            work_wdata_out <= next_work_wdata;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            stack_top_entry_out <= PC_RESET;
        end else begin
            stack_top_entry_out <= next_stack_top_entry;
        end
    end
endmodule

// *** design/btd_opcode_match.sv ***
// Opcode classifier for the decoder: pure combinational pattern matching.
// Assumes the instruction word is stable for the whole cycle.
`timescale 1ns/100ps
module btd_opcode_match
    import btd_pkg::*;
(
    // Instruction word
    input  wire logic [INSTR_W-1:0] instr_in,
    // Class strobes
    output logic                    is_test_clear_out,
    output logic                    is_test_set_out,
    output logic                    is_call_out,
    output logic                    is_zero_file_out,
    output logic                    is_zero_work_out
);
    assign is_test_clear_out = (instr_in[TEST_OP_HI:TEST_OP_LO] == OP_TEST_CLEAR);
    assign is_test_set_out   = (instr_in[TEST_OP_HI:TEST_OP_LO] == OP_TEST_SET);
    assign is_call_out       = (instr_in[INSTR_W-1:PC_W] == OP_CALL);
    assign is_zero_file_out  = (instr_in[INSTR_W-1:FADDR_W] == OP_ZERO_FILE);
    assign is_zero_work_out  = (instr_in == OP_ZERO_WORK);
endmodule

// *** inc/btd_pkg.sv ***
// Constants for the bit-test, call and clear instruction decoder.
// Assumes a 14-bit instruction word and a 12-bit program counter.
package btd_pkg;
    localparam int          INSTR_W        = 14;
    localparam int          PC_W           = 12;
    localparam int          DATA_W         = 8;
    localparam int          FADDR_W        = 7;
    // Bit-test opcode fields: bits 13:9 select the group, 8:6 the bit, 5:0 the file.
    localparam logic [4:0]  OP_TEST_CLEAR  = 5'h0A;
    localparam logic [4:0]  OP_TEST_SET    = 5'h0B;
    localparam int          TEST_OP_HI     = 13;
    localparam int          TEST_OP_LO     = 9;
    localparam int          BIT_HI         = 8;
    localparam int          BIT_LO         = 6;
    localparam int          TFILE_HI       = 5;
    // Call: bits 13:12 equal 10b, bits 11:0 target.
    localparam logic [1:0]  OP_CALL        = 2'h2;
    // Clear file: bits 13:7 equal 0000011b, bits 6:0 address.
    localparam logic [6:0]  OP_ZERO_FILE   = 7'h03;
    localparam logic [13:0] OP_ZERO_WORK   = 14'h0140;
    localparam logic [7:0]  ZERO_DATA      = 8'h00;
    localparam logic [11:0] PC_RESET       = 12'h000;
    localparam logic [11:0] PC_ONE         = 12'h001;
    typedef enum logic [1:0] {BTD_EXEC, BTD_FLUSH, BTD_CALL2} btd_state_t;
endpackage

// *** test/bit_test_call_clear_decode_test.sv ***
// Random self-checking bench for the decoder.
// Assumes the package, decoder and checker are compiled first.
`timescale 1ns/100ps
module bit_test_call_clear_decode_test;
    import btd_pkg::*;
    logic clk_in = 0, rst_in = 1, instr_valid_in = 0, tk, cl, zf, zw, sk;
    logic file_we_out, work_we_out, zero_set_out, pc_load_out, stack_push_out, stall_out, discard_out;
    logic [13:0] instr_in = 0;
    logic [11:0] pc_in = 0, pc_target_out, stack_top_entry_out, ret = 0;
    logic [7:0] file_data_in = 0, file_wdata_out, work_wdata_out;
    logic [6:0] file_addr_out;
    logic [15:0] r = 16'h0057, v;
    int fails = 0, total_checks = 0, mode = 0;
    always #25 clk_in = ~clk_in;
    btd_decoder i_dut (.clk_in, .rst_in, .instr_in, .instr_valid_in, .pc_in, .file_addr_out, .file_data_in,
        .file_we_out, .file_wdata_out, .work_we_out, .work_wdata_out, .zero_set_out, .pc_load_out,
        .pc_target_out, .stack_push_out, .stack_top_entry_out, .stall_out, .discard_out);
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    // Bit tests are 01 01xb bbff ffff; bit 9 picks skip-if-set, which skips when the bit equals it.
    function automatic logic exp_skip(input logic [13:0] ins, input logic [7:0] data);
        return ins[13:10] == 4'h5 && data[ins[8:6]] == ins[9];
    endfunction
    function automatic logic [6:0] exp_addr(input logic [13:0] ins);
        return ins[13:10] == 4'h5 ? {1'b0, ins[5:0]} : ins[6:0];
    endfunction
    task automatic chk(input logic ok);
        total_checks++;
        if (!ok) begin
            fails++;
            $display("Error %0t: output mismatch", $time);
        end
    endtask
    task automatic report_and_stop;
        $display("Checks %0d, errors %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk_in);
        rst_in <= 1'b0;
        for (int i = 0; i < 900; i++) begin
            @(posedge clk_in);
            r = lfsr(r);
            // Now and then all low fields are ones: top target, top address, bit 7, and a PC that wraps.
            v = r[12:11] == 2'h0 ? r | 16'h0FFF : r;
            instr_in <= v[15] ? v[13:0] : v[14] ? {OP_CALL, v[11:0]} : v[13] ? {OP_ZERO_FILE, v[6:0]}
                : v[12] ? OP_ZERO_WORK : {4'h5, v[9:0]};
            instr_valid_in <= r[10:9] != 2'h0;
            pc_in <= v[11:0];
            file_data_in <= r[15:8];
            @(negedge clk_in);
            tk = instr_valid_in && mode == 0;
            cl = tk && instr_in[13:12] == OP_CALL;
            zf = tk && instr_in[13:7] == OP_ZERO_FILE;
            zw = tk && instr_in == OP_ZERO_WORK;
            sk = tk && exp_skip(instr_in, file_data_in);
            chk(discard_out === (mode == 1) && stall_out === (mode == 2));
            chk(pc_load_out === cl && stack_push_out === cl && (!cl || pc_target_out === instr_in[11:0]));
            chk(mode != 2 || stack_top_entry_out === ret);
            chk(file_we_out === zf && work_we_out === zw && zero_set_out === (zf || zw));
            chk(file_addr_out === exp_addr(instr_in));
            chk(file_wdata_out === 8'h00 && work_wdata_out === 8'h00);
            mode = sk ? 1 : cl ? 2 : 0;
            if (cl) ret = pc_in + PC_ONE;
        end
        report_and_stop;
    end
endmodule

// *** test/btd_decoder_asserts.sv ***
// Port assertions for the decoder.
// Assumes it is bound to btd_decoder.
`timescale 1ns/100ps
module btd_decoder_asserts
    import btd_pkg::*;
(
    input wire logic        clk_in, rst_in, instr_valid_in, stall_out, discard_out, pc_load_out,
    input wire logic        stack_push_out, file_we_out, work_we_out, zero_set_out,
    input wire logic [13:0] instr_in,
    input wire logic [11:0] pc_in, pc_target_out, stack_top_entry_out,
    input wire logic [7:0]  file_data_in, file_wdata_out, work_wdata_out,
    input wire logic [6:0]  file_addr_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // Refused cycles are left out, so a skipped word never counts as a request.
    wire tk = instr_valid_in && !stall_out && !discard_out;
    wire cl = tk && instr_in[13:12] == OP_CALL;
    wire bt = tk && instr_in[13:10] == 4'h5;
    property p_call; cl |-> pc_load_out && stack_push_out && pc_target_out == instr_in[11:0]; endproperty
    a_call: assert property (p_call) else $error("call strobes wrong");
    property p_push; cl |=> stack_top_entry_out == $past(pc_in) + PC_ONE; endproperty
    a_push: assert property (p_push) else $error("return address wrong");
    property p_two; cl |=> stall_out && !pc_load_out ##1 !stall_out; endproperty
    a_two: assert property (p_two) else $error("call length wrong");
    property p_skip; bt |=> discard_out == ($past(file_data_in[instr_in[8:6]]) == $past(instr_in[9])); endproperty
    a_skip: assert property (p_skip) else $error("skip wrong");
    property p_bit; bt |-> file_addr_out == {1'b0, instr_in[5:0]} && !zero_set_out; endproperty
    a_bit: assert property (p_bit) else $error("bit test decode wrong");
    property p_zf; tk && instr_in[13:7] == OP_ZERO_FILE |-> file_we_out && zero_set_out
        && file_addr_out == instr_in[6:0] && file_wdata_out == 8'h00 ##1 !stall_out; endproperty
    a_zf: assert property (p_zf) else $error("file clear wrong");
    property p_zw; tk && instr_in == OP_ZERO_WORK |-> work_we_out && zero_set_out && work_wdata_out == 8'h00; endproperty
    a_zw: assert property (p_zw) else $error("work clear wrong");
    property p_nop; discard_out |-> !(file_we_out || work_we_out || zero_set_out || pc_load_out); endproperty
    a_nop: assert property (p_nop) else $error("skip slot not idle");
endmodule
bind btd_decoder btd_decoder_asserts i_chk (.clk_in, .rst_in, .instr_valid_in, .stall_out, .discard_out,
    .pc_load_out, .stack_push_out, .file_we_out, .work_we_out, .zero_set_out, .instr_in, .pc_in, .pc_target_out,
    .stack_top_entry_out, .file_data_in, .file_wdata_out, .work_wdata_out, .file_addr_out);
